// *** common/hps_pkg.sv ***
// Shared constants and types of the parallel host bus port.
`default_nettype none
package hps_pkg;
  // Interface mode; MD_INIT lasts until the strap is taken after reset.
  typedef enum logic [1:0] {
    MD_INIT = 2'b00,
    MD_DSRW = 2'b01,
    MD_RDWR = 2'b10,
    MD_MUX = 2'b11
  } hps_mode_t;
  // Address region of an access.
  typedef enum logic [1:0] {
    RG_REG = 2'b00,
    RG_FIFO = 2'b01,
    RG_TOP = 2'b10
  } hps_region_t;
  // Clock rates; the core clock is the port clock.
  localparam int CLK_PERIOD_PS = 10000;
  localparam int CORE_PERIOD_PS = 10000;
  // Least spacings, in tenths of a core clock period.
  localparam int GAP_REG_X10 = 15;
  localparam int GAP_RD_FIFO_B_X10 = 55;
  localparam int GAP_RD_FIFO_W_X10 = 65;
  localparam int GAP_RD_TOP_X10 = 55;
  localparam int GAP_WR_FIFO_B_X10 = 35;
  localparam int GAP_WR_FIFO_W_X10 = 45;
  localparam int GAP_WR_TOP_X10 = 35;
  localparam int LONG_RD_X10 = 50;
  // Least times round up to whole port clocks.
  function automatic int cyc_up(int x10);
    return (x10 * CORE_PERIOD_PS + 10 * CLK_PERIOD_PS - 1) / (10 * CLK_PERIOD_PS);
  endfunction
  localparam int GAP_CW = 4;
  localparam logic [GAP_CW-1:0] CYC_REG = GAP_CW'(cyc_up(GAP_REG_X10));
  localparam logic [GAP_CW-1:0] CYC_RD_FIFO_B = GAP_CW'(cyc_up(GAP_RD_FIFO_B_X10));
  localparam logic [GAP_CW-1:0] CYC_RD_FIFO_W = GAP_CW'(cyc_up(GAP_RD_FIFO_W_X10));
  localparam logic [GAP_CW-1:0] CYC_RD_TOP = GAP_CW'(cyc_up(GAP_RD_TOP_X10));
  localparam logic [GAP_CW-1:0] CYC_WR_FIFO_B = GAP_CW'(cyc_up(GAP_WR_FIFO_B_X10));
  localparam logic [GAP_CW-1:0] CYC_WR_FIFO_W = GAP_CW'(cyc_up(GAP_WR_FIFO_W_X10));
  localparam logic [GAP_CW-1:0] CYC_WR_TOP = GAP_CW'(cyc_up(GAP_WR_TOP_X10));
  localparam logic [GAP_CW-1:0] CYC_LONG_RD = GAP_CW'(cyc_up(LONG_RD_X10));
  // Lane patterns, active low, lane 3 leftmost.
  localparam logic [3:0] LN_NONE = 4'hF;
  localparam logic [3:0] LN_B0 = 4'hE;
  localparam logic [3:0] LN_B1 = 4'hD;
  localparam logic [3:0] LN_B2 = 4'hB;
  localparam logic [3:0] LN_B3 = 4'h7;
  localparam logic [3:0] LN_WLO = 4'hC;
  localparam logic [3:0] LN_WHI = 4'h3;
  localparam logic [3:0] LN_DW = 4'h0;
  localparam logic [1:0] LN_UPPER_OFF = 2'h3;
  // Reset values.
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [31:0] DATA_RST = 32'h0000_0000;
  localparam logic [23:0] PAD_ZERO = 24'h00_0000;
endpackage
`default_nettype wire

// *** logic/hps_gap_check.sv ***
// Strobe spacing and read length monitor of the host port.
`default_nettype none
module hps_gap_check (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Strobe state of the current access.
  input wire logic busyLow,
  input wire logic isWrite,
  input wire hps_pkg::hps_region_t region,
  input wire logic wide,
  // Spacing results.
  output logic gapErr,
  output logic shortRead
);
  localparam logic [hps_pkg::GAP_CW-1:0] CNT_ONE = 4'h1;
  localparam logic [hps_pkg::GAP_CW-1:0] CNT_MAX = 4'hF;
  logic busyQ_ff;
  logic wrQ_ff;
  logic wideQ_ff;
  hps_pkg::hps_region_t regQ_ff;
  logic [hps_pkg::GAP_CW-1:0] lowCnt_ff;
  logic [hps_pkg::GAP_CW-1:0] highCnt_ff;
  logic [hps_pkg::GAP_CW-1:0] needGap_ff;
  logic gapErr_ff;
  logic short_ff;

  // Edges of the combined strobe and the spacing owed after an access.
  wire startEdge = busyLow & ~busyQ_ff;
  wire endEdge = ~busyLow & busyQ_ff;
  wire [hps_pkg::GAP_CW-1:0] fifoRd = wideQ_ff ? hps_pkg::CYC_RD_FIFO_W : hps_pkg::CYC_RD_FIFO_B;
  wire [hps_pkg::GAP_CW-1:0] fifoWr = wideQ_ff ? hps_pkg::CYC_WR_FIFO_W : hps_pkg::CYC_WR_FIFO_B;
  wire [hps_pkg::GAP_CW-1:0] fifoGap = wrQ_ff ? fifoWr : fifoRd;
  wire [hps_pkg::GAP_CW-1:0] topGap = wrQ_ff ? hps_pkg::CYC_WR_TOP : hps_pkg::CYC_RD_TOP;
  wire [hps_pkg::GAP_CW-1:0] nxtNeed = (regQ_ff == hps_pkg::RG_FIFO) ? fifoGap :
                                       (regQ_ff == hps_pkg::RG_TOP) ? topGap : hps_pkg::CYC_REG;
  wire lowSat = lowCnt_ff == CNT_MAX;
  wire highSat = highCnt_ff == CNT_MAX;

  // Low and high counters saturate; the idle count starts full so the first access is clean.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busyQ_ff <= 1'b0;
      lowCnt_ff <= 4'h0;
      highCnt_ff <= CNT_MAX;
    end else begin
      busyQ_ff <= busyLow;
      if (startEdge) lowCnt_ff <= CNT_ONE;
      else if (busyLow && !lowSat) lowCnt_ff <= 4'(lowCnt_ff + CNT_ONE);
      if (endEdge) highCnt_ff <= CNT_ONE;
      else if (!busyLow && !highSat) highCnt_ff <= 4'(highCnt_ff + CNT_ONE);
    end
  end

  // Access kind is held from the strobe start; owed spacing is set at its end.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wrQ_ff <= 1'b0;
      wideQ_ff <= 1'b0;
      regQ_ff <= hps_pkg::RG_REG;
      needGap_ff <= 4'h0;
      gapErr_ff <= 1'b0;
      short_ff <= 1'b0;
    end else begin
      if (startEdge) begin
        wrQ_ff <= isWrite;
        wideQ_ff <= wide;
        regQ_ff <= region;
      end
      gapErr_ff <= startEdge & (highCnt_ff < needGap_ff);
      if (endEdge) begin
        needGap_ff <= nxtNeed;
        short_ff <= ~wrQ_ff & (regQ_ff == hps_pkg::RG_TOP) & (lowCnt_ff < hps_pkg::CYC_LONG_RD);
      end
    end
  end

  assign gapErr = gapErr_ff;
  assign shortRead = short_ff;
endmodule // hps_gap_check
`default_nettype wire

// *** logic/hps_host_port.sv ***
// Parallel host bus port: strobe decode, lane select and internal register access.
`default_nettype none
module hps_host_port #(
  parameter logic [7:0] INT_DATA_ADDR = 8'h7E,
  parameter logic [7:0] ZCNT_LO = 8'h10,
  parameter logic [7:0] ZCNT_HI = 8'h13,
  parameter logic [7:0] FCNT_LO = 8'h14,
  parameter logic [7:0] FCNT_HI = 8'h15
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Host strobes and strap pin.
  input wire logic csN,
  input wire logic dataStrobeN,
  input wire logic rwWrN,
  input wire logic ale,
  // Host address and lane enables.
  input wire logic [7:0] addrPin,
  input wire logic lane0EnableN,
  input wire logic lane1EnableN,
  input wire logic lane2EnableN,
  input wire logic lane3EnableN,
  // Host data lines, split into input, output and lane enables.
  input wire logic [31:0] muxedBusIn,
  output logic [31:0] muxedBusOut,
  output logic [3:0] muxedBusOeN,
  // Internal register side.
  output logic [7:0] coreAddr,
  output logic [3:0] coreLaneN,
  output logic [31:0] coreWrData,
  output logic coreWr,
  output logic coreRd,
  input wire logic [31:0] coreRdData,
  input wire logic coreRdValid,
  // Status.
  output hps_pkg::hps_mode_t portMode,
  output logic accessErr,
  output logic gapErr,
  output logic shortRead
);
  hps_pkg::hps_mode_t mode_ff;
  hps_pkg::hps_mode_t nxt_mode;
  logic aleQ_ff;
  logic rdAct_ff;
  logic wrAct_ff;
  logic [7:0] addr_ff;
  logic [31:0] wrData_ff;
  logic [7:0] coreAddr_ff;
  logic [3:0] coreLaneN_ff;
  logic [31:0] coreWrData_ff;
  logic coreWr_ff;
  logic coreRd_ff;
  logic accessErr_ff;
  logic pendTop_ff;
  logic nxt_pendTop;
  logic [7:0] intBuf_ff;
  logic [31:0] busOut_ff;
  logic [3:0] busOeN_ff;
  logic gapErrW;
  logic shortReadW;

  // Mode flags and latch strobe edges.
  wire aleRise = ale & ~aleQ_ff;
  wire aleFall = ~ale & aleQ_ff;
  wire live = mode_ff != hps_pkg::MD_INIT;
  wire isMux = mode_ff == hps_pkg::MD_MUX;
  wire isDsrw = mode_ff == hps_pkg::MD_DSRW;

  // Mode sequence: strap taken one clock after release, muxed mode is final.
  always_comb begin
    case (mode_ff)
      hps_pkg::MD_INIT: nxt_mode = ale ? hps_pkg::MD_DSRW : hps_pkg::MD_RDWR;
      hps_pkg::MD_DSRW: nxt_mode = aleRise ? hps_pkg::MD_MUX : hps_pkg::MD_DSRW;
      hps_pkg::MD_RDWR: nxt_mode = aleRise ? hps_pkg::MD_MUX : hps_pkg::MD_RDWR;
      default: nxt_mode = hps_pkg::MD_MUX;
    endcase
  end

  // Strobe decode; the strap clock blocks all accesses.
  wire strobeLow = ~(dataStrobeN | csN);
  wire wrPinLow = ~(rwWrN | csN);
  wire rdLow = live & strobeLow & rwWrN;
  wire wrLow = live & (isDsrw ? (strobeLow & ~rwWrN) : wrPinLow);
  wire rdStart = rdLow & ~rdAct_ff;
  wire wrEnd = wrAct_ff & ~wrLow;

  // Effective lanes; outside muxed mode only lanes 1 and 0 exist.
  wire [3:0] laneN = {lane3EnableN, lane2EnableN, lane1EnableN, lane0EnableN};
  wire [3:0] laneEffN = isMux ? laneN : {hps_pkg::LN_UPPER_OFF, laneN[1:0]};

  // Address used by the access; muxed mode uses only the latched low byte.
  // held muxed address.
  wire [7:0] curAddr = isMux ? addr_ff : addrPin;
  wire a0 = curAddr[0];

  wire inFifo = curAddr[7:6] == 2'h2;
  wire inTop = curAddr[7:6] == 2'h3;
  wire hps_pkg::hps_region_t region = inTop ? hps_pkg::RG_TOP :
                                      inFifo ? hps_pkg::RG_FIFO : hps_pkg::RG_REG;

  wire legal16 = ((laneEffN == hps_pkg::LN_B0) & ~a0) |
                 ((laneEffN == hps_pkg::LN_B1) & a0) |
                 ((laneEffN == hps_pkg::LN_WLO) & ~a0);
  wire legal32 = ((laneEffN == hps_pkg::LN_B2) & ~a0) |
                 ((laneEffN == hps_pkg::LN_B3) & a0) |
                 ((laneEffN == hps_pkg::LN_WHI) & ~a0) |
                 ((laneEffN == hps_pkg::LN_DW) & ~a0);
  wire legal = legal16 | (isMux & legal32);
  wire single = (laneEffN == hps_pkg::LN_B0) | (laneEffN == hps_pkg::LN_B1) |
                (laneEffN == hps_pkg::LN_B2) | (laneEffN == hps_pkg::LN_B3);
  wire wide = legal & ~single;

  // Counter addresses that may be read wide.
  wire zCnt = (curAddr >= ZCNT_LO) && (curAddr <= ZCNT_HI);
  wire fCnt = (curAddr >= FCNT_LO) && (curAddr <= FCNT_HI);
  wire rdWidthOk = single | inFifo | zCnt | (fCnt & (laneEffN != hps_pkg::LN_DW));
  wire wrWidthOk = single | inFifo;

  // low byte is a plain access.
  wire rdOk = rdStart & legal & rdWidthOk;
  wire wrOk = wrEnd & legal & wrWidthOk;
  wire rdBad = rdStart & ~(legal & rdWidthOk);
  wire wrBad = wrEnd & ~(legal & wrWidthOk);
  wire bufHit = curAddr == INT_DATA_ADDR;
  wire fetch = rdOk & ~bufHit;
  wire topFetch = fetch & inTop;

  // Pending top fetch; a new top fetch in the answer cycle keeps the flag set.
  always_comb begin
    nxt_pendTop = topFetch | (pendTop_ff & ~coreRdValid);
  end

  // Mode, strap edge memory and strobe history.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_ff <= hps_pkg::MD_INIT;
      aleQ_ff <= 1'b0;
      rdAct_ff <= 1'b0;
      wrAct_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      aleQ_ff <= ale;
      rdAct_ff <= rdLow;
      wrAct_ff <= wrLow;
    end
  end

  // Address latch and write data capture.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addr_ff <= hps_pkg::ADDR_RST;
      wrData_ff <= hps_pkg::DATA_RST;
    end else begin
      if (isMux && aleFall) addr_ff <= muxedBusIn[7:0];
      if (wrLow) wrData_ff <= muxedBusIn;
    end
  end

  // Requests to the internal register side.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      coreAddr_ff <= hps_pkg::ADDR_RST;
      coreLaneN_ff <= hps_pkg::LN_NONE;
      coreWrData_ff <= hps_pkg::DATA_RST;
      coreWr_ff <= 1'b0;
      coreRd_ff <= 1'b0;
      accessErr_ff <= 1'b0;
    end else begin
      coreWr_ff <= wrOk;
      coreRd_ff <= fetch;
      accessErr_ff <= rdBad | wrBad;
      if (wrOk || fetch) begin
        coreAddr_ff <= curAddr;
        coreLaneN_ff <= laneEffN;
      end
      if (wrOk) coreWrData_ff <= wrData_ff;
    end
  end

  // Read data and the short-read buffer.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pendTop_ff <= 1'b0;
      intBuf_ff <= hps_pkg::ADDR_RST;
      busOut_ff <= hps_pkg::DATA_RST;
    end else begin
      pendTop_ff <= nxt_pendTop;
      if (coreRdValid && pendTop_ff) intBuf_ff <= coreRdData[7:0];
      if (rdOk && bufHit) busOut_ff <= {hps_pkg::PAD_ZERO, intBuf_ff};
      else if (coreRdValid) busOut_ff <= coreRdData;
    end
  end

  // Lane drivers; each lane drives only during a read with its enable low.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) busOeN_ff[gi] <= 1'b1;
        else busOeN_ff[gi] <= ~(rdLow & ~laneEffN[gi]);
      end
    end
  endgenerate

  // Spacing monitor; it only reports, because the host owns these limits.
  hps_gap_check u_gap (
    .clk(clk),
    .nrst(nrst),
    .busyLow(rdLow | wrLow),
    .isWrite(wrLow),
    .region(region),
    .wide(wide),
    .gapErr(gapErrW),
    .shortRead(shortReadW)
  );

  // Outputs straight from flip-flops.
  assign muxedBusOut = busOut_ff;
  assign muxedBusOeN = busOeN_ff;
  assign coreAddr = coreAddr_ff;
  assign coreLaneN = coreLaneN_ff;
  assign coreWrData = coreWrData_ff;
  assign coreWr = coreWr_ff;
  assign coreRd = coreRd_ff;
  assign portMode = mode_ff;
  assign accessErr = accessErr_ff;
  assign gapErr = gapErrW;
  assign shortRead = shortReadW;

  // Checks on the port's own behaviour.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  wire lane0Drive = rdLow & ~laneEffN[0];
  wire wideRegWr = wrEnd & wide & (region == hps_pkg::RG_REG);

  sequence wrEnd_s;
    wrLow ##1 !wrLow;
  endsequence
  sequence topFetch_s;
    pendTop_ff && coreRdValid;
  endsequence
  sequence muxFall_s;
    isMux && aleFall;
  endsequence

  oe_lane_a: assert property (!busOeN_ff[0] |-> $past(lane0Drive))
    else $error("Lane 0 driven without read strobe and enable.");
  upper_off_a: assert property (live && !isMux |=> busOeN_ff[3:2] == 2'h3)
    else $error("Upper lanes driven outside muxed mode.");
  wr_end_a: assert property (wrEnd_s |=> (coreWr_ff || accessErr_ff))
    else $error("Write strobe end gave no write or error.");
  addr_latch_a: assert property (muxFall_s |=> addr_ff == $past(muxedBusIn[7:0]))
    else $error("Muxed address not latched on strobe fall.");
  addr_keep_a: assert property (!aleFall |=> $stable(addr_ff))
    else $error("Latched address changed without strobe fall.");
  mode_final_a: assert property (isMux |=> isMux [*3])
    else $error("Muxed mode was left.");
  strap_once_a: assert property (mode_ff == hps_pkg::MD_INIT && nrst |=> live)
    else $error("Strap not taken one clock after reset.");
  byte_write_a: assert property (
    coreWr_ff && coreAddr_ff[7:6] != 2'h2 |-> $onehot(~coreLaneN_ff))
    else $error("Wide write outside FIFO region.");
  lane_a0_a: assert property (
    (coreWr_ff || coreRd_ff) && coreLaneN_ff == hps_pkg::LN_B3 |-> coreAddr_ff[0])
    else $error("Top byte lane accepted with address bit 0 low.");
  buf_fill_a: assert property (topFetch_s |=> intBuf_ff == $past(coreRdData[7:0]))
    else $error("Top fetch not buffered.");
  wide_reg_a: assert property (wideRegWr |=> accessErr_ff && !coreWr_ff)
    else $error("Wide write to ordinary register accepted.");
endmodule // hps_host_port
`default_nettype wire

// *** verification/hps_host_model.sv ***
// Host processor model that drives the port's bus pins from tasks.
`default_nettype none
module hps_host_model (
  // Clock.
  input wire logic clk,
  // Bus pins toward the port.
  output logic csN,
  output logic dataStrobeN,
  output logic rwWrN,
  output logic ale,
  output logic [7:0] addrPin,
  output logic [3:0] laneN,
  output logic [31:0] busIn,
  // Port drive seen by the host.
  input wire logic [31:0] busOut,
  input wire logic [3:0] busOeN,
  // Values sampled in the last low cycle of a read.
  output logic [31:0] rdData,
  output logic [3:0] rdOeN
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus; the strap stays low so the port starts with separate strobes.
  initial begin
    csN = 1'b1;
    dataStrobeN = 1'b1;
    rwWrN = 1'b1;
    ale = 1'b0;
    addrPin = 8'h00;
    laneN = 4'hF;
    busIn = 32'h0000_0000;
  end
  // caller sets width, lanes and idle time.
  task automatic write(input logic [7:0] a, input logic [3:0] ln, input logic [31:0] d,
      input int lowCyc, input int idleCyc);
    csN <= 1'b0;
    rwWrN <= 1'b0;
    addrPin <= a;
    laneN <= ln;
    busIn <= d;
    repeat (lowCyc) @(posedge clk);
    csN <= 1'b1;
    rwWrN <= 1'b1;
    // Lines are held one clock for hold time, then float to the inverse value.
    @(posedge clk);
    laneN <= 4'hF;
    busIn <= ~d;
    repeat (idleCyc - 1) @(posedge clk);
  endtask
  // caller sets strobe length, width and idle.
  task automatic read(input logic [7:0] a, input logic [3:0] ln, input int lowCyc,
      input int idleCyc);
    csN <= 1'b0;
    dataStrobeN <= 1'b0;
    rwWrN <= 1'b1;
    addrPin <= a;
    laneN <= ln;
    repeat (lowCyc) @(posedge clk);
    rdData = busOut;
    rdOeN = busOeN;
    csN <= 1'b1;
    dataStrobeN <= 1'b1;
    @(posedge clk);
    laneN <= 4'hF;
    addrPin <= ~a;
    repeat (idleCyc - 1) @(posedge clk);
  endtask
  // Address phase; the value stays two clocks past the strobe fall for margin.
  task automatic latch(input logic [31:0] v);
    ale <= 1'b1;
    busIn <= v;
    @(posedge clk);
    ale <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    busIn <= ~v;
    @(posedge clk);
  endtask
  // Strap level that the port takes at the next reset release.
  task automatic strap(input logic v);
    ale <= v;
  endtask
  // Strobe plus direction write; direction stays low one clock past the strobe for hold.
  task automatic writeDs(input logic [7:0] a, input logic [3:0] ln, input logic [31:0] d,
      input int lowCyc, input int idleCyc);
    csN <= 1'b0;
    dataStrobeN <= 1'b0;
    rwWrN <= 1'b0;
    addrPin <= a;
    laneN <= ln;
    busIn <= d;
    repeat (lowCyc) @(posedge clk);
    csN <= 1'b1;
    dataStrobeN <= 1'b1;
    @(posedge clk);
    rwWrN <= 1'b1;
    laneN <= 4'hF;
    busIn <= ~d;
    repeat (idleCyc - 1) @(posedge clk);
  endtask
endmodule // hps_host_model
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking bench of the parallel host bus port.
`default_nettype none
`define CHK(nm, e, g) begin testsRun++; if ((g) !== (e)) begin errorCnt++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // Clock, reset and pins.
  logic clk;
  logic nrst;
  logic csN, dataStrobeN, rwWrN, ale;
  logic [7:0] addrPin;
  logic [3:0] laneN;
  logic [31:0] muxedBusIn, muxedBusOut, rdData;
  logic [3:0] muxedBusOeN, rdOeN;
  // Internal side and status.
  logic [7:0] coreAddr;
  logic [3:0] coreLaneN;
  logic [31:0] coreWrData;
  logic coreWr, coreRd, accessErr, gapErr, shortRead;
  logic [31:0] coreRdData = 32'h0000_0000;
  logic coreRdValid = 1'b0;
  hps_pkg::hps_mode_t portMode;
  // Responder pipeline, captures and counters.
  logic rdV1 = 1'b0;
  logic [7:0] rdA1 = 8'h00;
  logic [7:0] wrAddr;
  logic [3:0] wrLane;
  logic [31:0] wrData;
  int testsRun = 0;
  int errorCnt = 0;
  int rdCnt = 0, wrCnt = 0, gapCnt = 0, errCnt = 0, cycles = 0;

  // Register contents the responder returns, so each address reads back differently.
  function automatic logic [31:0] expData(input logic [7:0] a);
    return {a, ~a, 8'hA5, a ^ 8'h3C};
  endfunction

  hps_host_port i_hps_host_port (
    .clk(clk), .nrst(nrst), .csN(csN), .dataStrobeN(dataStrobeN), .rwWrN(rwWrN),
    .ale(ale), .addrPin(addrPin), .lane0EnableN(laneN[0]), .lane1EnableN(laneN[1]),
    .lane2EnableN(laneN[2]), .lane3EnableN(laneN[3]), .muxedBusIn(muxedBusIn),
    .muxedBusOut(muxedBusOut), .muxedBusOeN(muxedBusOeN), .coreAddr(coreAddr),
    .coreLaneN(coreLaneN), .coreWrData(coreWrData), .coreWr(coreWr), .coreRd(coreRd),
    .coreRdData(coreRdData), .coreRdValid(coreRdValid), .portMode(portMode),
    .accessErr(accessErr), .gapErr(gapErr), .shortRead(shortRead)
  );

  hps_host_model i_hps_host_model (
    .clk(clk), .csN(csN), .dataStrobeN(dataStrobeN), .rwWrN(rwWrN), .ale(ale),
    .addrPin(addrPin), .laneN(laneN), .busIn(muxedBusIn), .busOut(muxedBusOut),
    .busOeN(muxedBusOeN), .rdData(rdData), .rdOeN(rdOeN)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Responder answers two clocks late; counters use non-blocking updates so tasks
  // reading them at an edge never race the increment.
  always @(posedge clk) begin
    rdV1 <= coreRd;
    rdA1 <= coreAddr;
    coreRdValid <= rdV1;
    coreRdData <= expData(rdA1);
    rdCnt <= rdCnt + int'(coreRd);
    wrCnt <= wrCnt + int'(coreWr);
    gapCnt <= gapCnt + int'(gapErr);
    errCnt <= errCnt + int'(accessErr);
    if (coreWr === 1'b1) begin
      wrAddr <= coreAddr;
      wrLane <= coreLaneN;
      wrData <= coreWrData;
    end
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errorCnt++;
      $display("Run exceeded its cycle ceiling");
      conclude();
    end
  end

  task automatic testWrite();
    int w0;
    int e0;
    w0 = wrCnt;
    e0 = errCnt;
    i_hps_host_model.write(8'h04, 4'hE, 32'h0000_00AB, 2, 6);
    `CHK("wrAddr", 8'h04, wrAddr)
    `CHK("wrByte", 8'hAB, wrData[7:0])
    i_hps_host_model.write(8'h80, 4'hC, 32'hFFFF_1234, 2, 6);
    `CHK("wrLane", 4'hC, wrLane)
    `CHK("wrWord", 16'h1234, wrData[15:0])
    i_hps_host_model.write(8'h06, 4'hC, 32'h0000_5555, 2, 6);
    `CHK("wrCount", w0 + 2, wrCnt)
    `CHK("wrRefused", e0 + 1, errCnt)
    $display("test write done");
  endtask

  task automatic testRead();
    int r0;
    int e0;
    logic [31:0] e;
    r0 = rdCnt;
    e0 = errCnt;
    e = expData(8'h04);
    i_hps_host_model.read(8'h04, 4'hE, 8, 3);
    `CHK("oeByte", 4'hE, rdOeN)
    `CHK("rdByte", e[7:0], rdData[7:0])
    `CHK("oeOff", 4'hF, muxedBusOeN)
    e = expData(8'h14);
    i_hps_host_model.read(8'h14, 4'hC, 8, 3);
    `CHK("oeWord", 4'hC, rdOeN)
    `CHK("rdWord", e[15:0], rdData[15:0])
    i_hps_host_model.read(8'h20, 4'hC, 8, 3);
    `CHK("rdCount", r0 + 2, rdCnt)
    `CHK("rdRefused", e0 + 1, errCnt)
    $display("test read done");
  endtask

  task automatic testGap();
    int g0;
    g0 = gapCnt;
    i_hps_host_model.read(8'h05, 4'hE, 2, 1);
    i_hps_host_model.read(8'h05, 4'hE, 2, 2);
    i_hps_host_model.read(8'h05, 4'hE, 2, 8);
    `CHK("gapRead", g0 + 1, gapCnt)
    i_hps_host_model.write(8'h80, 4'hE, 32'h0000_0011, 2, 3);
    i_hps_host_model.write(8'h80, 4'hE, 32'h0000_0022, 2, 4);
    i_hps_host_model.write(8'h80, 4'hE, 32'h0000_0033, 2, 8);
    `CHK("gapWrite", g0 + 2, gapCnt)
    $display("test spacing done");
  endtask

  task automatic testShort();
    int r0;
    logic [31:0] e;
    e = expData(8'hC0);
    i_hps_host_model.read(8'hC0, 4'hE, 2, 8);
    `CHK("shortSet", 1'b1, shortRead)
    r0 = rdCnt;
    i_hps_host_model.read(8'h7E, 4'hE, 4, 8);
    `CHK("bufData", e[7:0], rdData[7:0])
    `CHK("noFetch", r0, rdCnt)
    i_hps_host_model.read(8'hC0, 4'hE, 8, 8);
    `CHK("shortClr", 1'b0, shortRead)
    $display("test short read done");
  endtask

  task automatic testMux();
    int e0;
    logic [31:0] e;
    e = expData(8'h80);
    i_hps_host_model.latch(32'h0000_0000);
    `CHK("muxMode", hps_pkg::MD_MUX, portMode)
    i_hps_host_model.latch(32'hDEAD_BE80);
    i_hps_host_model.write(8'h00, 4'h0, 32'h89AB_CDEF, 2, 6);
    `CHK("muxAddr", 8'h80, wrAddr)
    `CHK("dwLane", 4'h0, wrLane)
    `CHK("dwData", 32'h89AB_CDEF, wrData)
    i_hps_host_model.write(8'h00, 4'hC, 32'h0000_4567, 2, 6);
    `CHK("reuseAddr", 8'h80, wrAddr)
    i_hps_host_model.read(8'h00, 4'hB, 8, 8);
    `CHK("laneOe", 4'hB, rdOeN)
    `CHK("lane2", e[23:16], rdData[23:16])
    i_hps_host_model.read(8'h00, 4'h0, 8, 8);
    `CHK("dwRead", e, rdData)
    e0 = errCnt;
    i_hps_host_model.read(8'h00, 4'h7, 8, 8);
    `CHK("badLane", e0 + 1, errCnt)
    $display("test muxed done");
  endtask

  // Second reset with the strap high selects strobe plus direction; then a write and a read.
  task automatic testStrobeDir();
    logic [31:0] e;
    e = expData(8'h04);
    i_hps_host_model.strap(1'b1);
    nrst <= 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("dsMode", hps_pkg::MD_DSRW, portMode)
    `CHK("dsOeReset", 4'hF, muxedBusOeN)
    i_hps_host_model.writeDs(8'h04, 4'hE, 32'h0000_005A, 2, 6);
    `CHK("dsAddr", 8'h04, wrAddr)
    `CHK("dsData", 8'h5A, wrData[7:0])
    i_hps_host_model.read(8'h04, 4'hE, 8, 3);
    `CHK("dsOe", 4'hE, rdOeN)
    `CHK("dsRead", e[7:0], rdData[7:0])
    $display("test strobe direction done");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", testsRun, errorCnt);
    if (errorCnt == 0 && testsRun > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Reset, then the scenarios in order; muxed mode is permanent, so only a second reset
  // with the strap high can follow it.
  initial begin
    nrst = 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("strapMode", hps_pkg::MD_RDWR, portMode)
    `CHK("oeReset", 4'hF, muxedBusOeN)
    testWrite();
    testRead();
    testGap();
    testShort();
    testMux();
    testStrobeDir();
    conclude();
  end
endmodule // testbench
`default_nettype wire
